// File: src/bpc_pkg.sv
// Purpose: shared constants and types for bus polarity correction
// Assumes: 100 MHz system clock
// Notes:   timing counts derive from times in their own units
package bpc_pkg;
   localparam int CLK_NS  = 10;
   localparam int CLK_MHZ = 100;
   localparam int US_PER_MS = 1000;
   // typical idle window, inside the 44..76 ms band
   localparam int IDLE_WIN_MS  = 58;
   localparam int IDLE_WIN_CYC = IDLE_WIN_MS * US_PER_MS * CLK_MHZ;
   localparam int STBY_NS  = 300;
   localparam int STBY_CYC = (STBY_NS + CLK_NS - 1) / CLK_NS;
   // edges from reset release until synchronised pins are valid
   localparam int SYNC_EDGES = 4;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STAT = 4'h4;
   localparam int CTRL_DET_EN_BIT = 0;
   localparam int CTRL_REARM_BIT  = 1;
   localparam logic CTRL_DET_EN_RST = 1'h1;
   localparam int STAT_SWAP_BIT  = 0;
   localparam int STAT_LOCK_BIT  = 1;
   localparam int STAT_STBY_BIT  = 2;
   localparam int STAT_VALID_BIT = 3;
   localparam int STAT_DET_BIT   = 4;

   typedef enum logic [1:0] {
      BPC_DETECT,
      BPC_SWAPPED,
      BPC_LOCKED
   } bpc_mode_t;
endpackage

// File: src/bpc_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: pins asynchronous to clk_in
// Notes:   a change counts once stages two and three agree
`timescale 1ns/1ns
module bpc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         sys_rst_in,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] lvl_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } bpc_sync_t;

   bpc_sync_t q;
   bpc_sync_t n;

   always_comb begin
      n     = q;
      n.s1  = pin_in;
      n.s2  = q.s1;
      n.s3  = q.s2;
      // s1 feeds only s2; the filter looks at s2 and s3
      n.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 ^ q.s3));
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign lvl_out = q.lvl;
endmodule

// File: src/bpc_timer.sv
// Purpose: interval timer, done after LIMIT cycles of run
// Assumes: clr or run low restarts from zero
// Notes:   done holds while run stays high
`timescale 1ns/1ns
module bpc_timer #(
   parameter int LIMIT = 4,
   parameter int W     = $clog2(LIMIT + 1)
) (
   input  wire logic clk_in,
   input  wire logic sys_rst_in,
   bpc_timer_if.tmr  tif
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         done;
   } bpc_timer_t;

   bpc_timer_t q;
   bpc_timer_t n;

   always_comb begin
      n = q;
      if (tif.clr || !tif.run) begin
         n.cnt  = '0;
         n.done = 1'b0;
      end else if (!q.done) begin
         if (q.cnt == W'(LIMIT - 1)) begin
            n.done = 1'b1;
         end else begin
            n.cnt = q.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign tif.done = q.done;
endmodule

// File: src/bpc_timer_if.sv
// Purpose: request and status of one interval timer
// Assumes: one clock domain
// Notes:   run low also restarts the count
`timescale 1ns/1ns
interface bpc_timer_if;
   logic clr;
   logic run;
   logic done;
   modport ctl (output clr, output run, input done);
   modport tmr (input clr, input run, output done);
endinterface

// File: src/bpc_top.sv
// Purpose: polarity correction, driver and receiver gating
// Assumes: bus levels arrive as two comparator flags
// Notes:   all eight enable, data and comparator pins pass the three-stage synchroniser; register inputs do not
`timescale 1ns/1ns
module bpc_top
   import bpc_pkg::*;
#(
   parameter int IDLE_WIN_CYC_P = IDLE_WIN_CYC
) (
   input  wire logic              clk_in,
   input  wire logic              sys_rst_in,
   input  wire logic              talk_gate_in,
   input  wire logic              talk_open_in,
   input  wire logic              listen_gate_low_in,
   input  wire logic              listen_open_in,
   input  wire logic              tx_bit_in,
   input  wire logic              tx_open_in,
   input  wire logic              bus_above_upper_in,
   input  wire logic              bus_below_lower_in,
   input  wire logic [ADDR_W-1:0] reg_addr_in,
   input  wire logic [DATA_W-1:0] reg_wdata_in,
   input  wire logic              reg_wr_in,
   input  wire logic              reg_rd_in,
   output logic      [DATA_W-1:0] reg_rdata_out,
   output logic                   bus_a_out,
   output logic                   bus_a_oe_n_out,
   output logic                   bus_b_out,
   output logic                   bus_b_oe_n_out,
   output logic                   sensed_bit_out,
   output logic                   sensed_oe_n_out,
   output logic                   sensed_valid_out,
   output logic                   swap_active_out,
   output logic                   standby_out
);
   typedef struct packed {
      bpc_mode_t         mode;
      logic              swap;
      logic              det_en;
      logic              dis_prev;
      logic [2:0]        warm;
      logic              rx_lvl;
      logic              a;
      logic              b;
      logic              drv_oe_n;
      logic              sensed;
      logic              s_oe_n;
      logic              s_valid;
      logic [DATA_W-1:0] rdata;
   } bpc_state_t;

   bpc_state_t q;
   bpc_state_t n;

   logic talk_s;
   logic talk_open_s;
   logic listen_low_s;
   logic listen_open_s;
   logic tx_s;
   logic tx_open_s;
   logic bus_hi_s;
   logic bus_lo_s;
   logic talk_en;
   logic listen_dis;
   logic listen_rise;
   logic tx_eff;
   logic rearm;
   logic stby_cond;
   logic warm_done;

   bpc_timer_if win_if ();
   bpc_timer_if stby_if ();

   bpc_sync #(
      .W (8)
   ) u_sync (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .pin_in     ({talk_gate_in, talk_open_in, listen_gate_low_in,
                    listen_open_in, tx_bit_in, tx_open_in,
                    bus_above_upper_in, bus_below_lower_in}),
      .lvl_out    ({talk_s, talk_open_s, listen_low_s,
                    listen_open_s, tx_s, tx_open_s,
                    bus_hi_s, bus_lo_s})
   );

   // idle window; shorten IDLE_WIN_CYC_P in simulation
   bpc_timer #(
      .LIMIT (IDLE_WIN_CYC_P)
   ) u_win (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .tif        (win_if.tmr)
   );

   bpc_timer #(
      .LIMIT (STBY_CYC)
   ) u_stby (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .tif        (stby_if.tmr)
   );

   // an open enable pin counts as disabled
   assign talk_en     = talk_s & ~talk_open_s;
   assign listen_dis  = listen_low_s | listen_open_s;
   // pins read low until the sync fills; no latch edge before then
   assign warm_done   = (q.warm == 3'(SYNC_EDGES));
   assign listen_rise = listen_dis & ~q.dis_prev & warm_done;
   // open data input drives as a high bit
   assign tx_eff      = tx_s | tx_open_s;
   assign rearm       = reg_wr_in && (reg_addr_in == REG_CTRL)
                        && reg_wdata_in[CTRL_REARM_BIT];

   // bus low, driver off, still detecting; anything else restarts
   assign win_if.clr = rearm;
   assign win_if.run = q.det_en && (q.mode == BPC_DETECT)
                       && bus_lo_s && !talk_en;

   assign stby_cond  = !talk_en && listen_dis;
   assign stby_if.clr = 1'b0;
   assign stby_if.run = stby_cond;

   always_comb begin
      n          = q;
      n.dis_prev = warm_done ? listen_dis : 1'b1;
      if (!warm_done) begin
         n.warm = q.warm + 3'h1;
      end
      if (reg_wr_in && (reg_addr_in == REG_CTRL)) begin
         n.det_en = reg_wdata_in[CTRL_DET_EN_BIT];
      end

      unique case (q.mode)
         BPC_DETECT: begin
            if (win_if.done) begin
               n.mode = BPC_SWAPPED;
               n.swap = 1'b1;
            end else if (listen_rise) begin
               n.mode = BPC_LOCKED;
            end
         end
         BPC_SWAPPED: begin
            if (listen_rise) begin
               n.mode = BPC_LOCKED;
            end
         end
         BPC_LOCKED: begin
            n.mode = BPC_LOCKED;
         end
         default: begin
            n.mode = BPC_DETECT;
         end
      endcase

      // software rearm returns mode to BPC_DETECT and clears swap
      // a window ending in the same cycle still swaps: set wins
      if (rearm && !(win_if.done && (q.mode == BPC_DETECT))) begin
         n.mode = BPC_DETECT;
         n.swap = 1'b0;
      end

      // receive level: hold last value in the dead band
      if (bus_hi_s) begin
         n.rx_lvl = 1'b1;
      end else if (bus_lo_s) begin
         n.rx_lvl = 1'b0;
      end
      n.s_valid = bus_hi_s | bus_lo_s;
      n.sensed  = n.rx_lvl ^ n.swap;
      n.s_oe_n  = listen_dis;

      n.a        = tx_eff ^ n.swap;
      n.b        = ~(tx_eff ^ n.swap);
      n.drv_oe_n = ~talk_en;

      n.rdata = '0;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            REG_CTRL: begin
               n.rdata[CTRL_DET_EN_BIT] = q.det_en;
            end
            REG_STAT: begin
               n.rdata[STAT_SWAP_BIT]  = q.swap;
               n.rdata[STAT_LOCK_BIT]  = (q.mode == BPC_LOCKED);
               n.rdata[STAT_STBY_BIT]  = stby_if.done;
               n.rdata[STAT_VALID_BIT] = q.s_valid;
               n.rdata[STAT_DET_BIT]   = (q.mode == BPC_DETECT);
            end
            default: begin
               n.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         q          <= '0;
         q.mode     <= BPC_DETECT;
         q.swap     <= 1'b0;
         q.det_en   <= CTRL_DET_EN_RST;
         q.dis_prev <= 1'b1;
         q.b        <= 1'b1;
         q.drv_oe_n <= 1'b1;
         q.s_oe_n   <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign reg_rdata_out    = q.rdata;
   assign bus_a_out        = q.a;
   assign bus_b_out        = q.b;
   assign bus_a_oe_n_out   = q.drv_oe_n;
   assign bus_b_oe_n_out   = q.drv_oe_n;
   assign sensed_bit_out   = q.sensed;
   assign sensed_oe_n_out  = q.s_oe_n;
   assign sensed_valid_out = q.s_valid;
   assign swap_active_out  = q.swap;
   assign standby_out      = stby_if.done;

   // helper: consecutive cycles with both enables off
   logic [15:0] dis_cnt_q;
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         dis_cnt_q <= '0;
      end else if (!stby_cond) begin
         dis_cnt_q <= '0;
      end else if (dis_cnt_q != 16'hFFFF) begin
         dis_cnt_q <= dis_cnt_q + 16'h0001;
      end
   end

   a_reset_no_swap: assert property (
      @(posedge clk_in) $fell(sys_rst_in) |-> !swap_active_out
   ) else $error("swap active right after reset");

   a_swap_needs_window: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      $rose(swap_active_out) |->
         $past(win_if.done) && $past(q.mode == BPC_DETECT)
   ) else $error("swap set without elapsed idle window");

   a_window_cond: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      win_if.done |-> $past(bus_lo_s) && $past(!talk_en)
   ) else $error("idle window ran with bus high or driver on");

   a_timer_restart: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      !win_if.run |=> !win_if.done
   ) else $error("idle timer did not restart");

   a_lock_holds: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (q.mode == BPC_LOCKED) && !rearm |=>
         (q.mode == BPC_LOCKED) && $stable(swap_active_out)
   ) else $error("latched polarity changed");

   a_no_early_latch: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      !warm_done |=> (q.mode != BPC_LOCKED)
   ) else $error("polarity latched before pins settled");

   a_drive_norm: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      talk_en && !q.swap && !win_if.done && !rearm |=>
         (bus_a_out == $past(tx_eff)) && (bus_b_out == !$past(tx_eff))
   ) else $error("normal drive polarity wrong");

   a_drive_swap: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      talk_en && q.swap && !rearm |=>
         (bus_a_out != $past(tx_eff)) && (bus_b_out == $past(tx_eff))
         && !bus_a_oe_n_out
   ) else $error("swapped drive polarity wrong");

   a_driver_off: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      !talk_en |=> bus_a_oe_n_out && bus_b_oe_n_out
   ) else $error("bus driven while driver disabled");

   a_rx_release: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      listen_dis |=> sensed_oe_n_out
   ) else $error("receiver output driven while disabled");

   a_rx_swap: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      bus_lo_s && q.swap && !rearm |=> sensed_bit_out && sensed_valid_out
   ) else $error("swapped receive did not read high");

   a_rx_norm: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      bus_hi_s && !q.swap && !win_if.done |=> sensed_bit_out
   ) else $error("normal receive did not read high");

   a_standby_time: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      $rose(standby_out) |-> dis_cnt_q == 16'(STBY_CYC)
   ) else $error("standby entered before its delay");

   a_standby_exit: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      !stby_cond |=> !standby_out
   ) else $error("standby with an enable active");

   c_swap: cover property (
      @(posedge clk_in) disable iff (sys_rst_in) $rose(swap_active_out)
   );

   c_lock_swapped: cover property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (q.mode == BPC_SWAPPED) ##1 (q.mode == BPC_LOCKED)
   );

   c_standby: cover property (
      @(posedge clk_in) disable iff (sys_rst_in) $rose(standby_out)
   );

   c_drive_swapped: cover property (
      @(posedge clk_in) disable iff (sys_rst_in)
      q.swap && !bus_a_oe_n_out
   );
endmodule

// File: verification/bpc_bus_model.sv
// Purpose: far side of the bus, other nodes and failsafe bias
// Assumes: comparator flags are seen at this node's own pins
// Notes:   a crossed pair flips every far-side level
`timescale 1ns/1ns
module bpc_bus_model (
   input  wire logic bus_a_in,
   input  wire logic bus_a_oe_n_in,
   input  wire logic bus_b_in,
   input  wire logic crossed_in,
   input  wire logic far_drv_in,
   input  wire logic far_bit_in,
   output logic      above_out,
   output logic      below_out
);
   logic diff_pos;
   // own driver wins; contention not modelled
   always_comb begin
      if (!bus_a_oe_n_in) begin
         diff_pos = bus_a_in & ~bus_b_in;
      end else if (far_drv_in) begin
         diff_pos = far_bit_in ^ crossed_in;
      end else begin
         // master bias holds idle high before sending
         diff_pos = ~crossed_in;
      end
      above_out = diff_pos;
      below_out = ~diff_pos;
   end
endmodule

// File: verification/tb_bpc_top.sv
// Purpose: self-checking bench for bus polarity correction
// Assumes: short idle window, crossed pair at start
// Notes:   pin results sampled 8 edges after each change
`timescale 1ns/1ns
module tb_bpc_top;
   import bpc_pkg::*;
   // stands in for the 44..76 ms window
   localparam int WIN = 50;
   localparam logic [7:0] M_RX = 8'hCF;
   logic              clk_in, sys_rst_in, talk, topen, lsn, lopen;
   logic              txb, txo, above, below, wr, rd, a, aoe, b, boe;
   logic              sb, soe, sval, swp, stby, crossed, fdrv, fbit;
   logic              smp, rd_seen;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [31:0]       rnd;
   logic [15:0]       pv;
   logic [7:0]        ov;
   logic [15:0]       pin_q[$];
   logic [31:0]       rd_q[$];
   int                fails, checks_done;

   bpc_top #(.IDLE_WIN_CYC_P(WIN)) bpc_top_inst (
      .clk_in, .sys_rst_in, .talk_gate_in(talk), .talk_open_in(topen),
      .listen_gate_low_in(lsn), .listen_open_in(lopen),
      .tx_bit_in(txb), .tx_open_in(txo),
      .bus_above_upper_in(above), .bus_below_lower_in(below),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_rdata_out(rdata), .bus_a_out(a),
      .bus_a_oe_n_out(aoe), .bus_b_out(b), .bus_b_oe_n_out(boe),
      .sensed_bit_out(sb), .sensed_oe_n_out(soe),
      .sensed_valid_out(sval), .swap_active_out(swp),
      .standby_out(stby));

   bpc_bus_model bpc_bus_model_inst (
      .bus_a_in(a), .bus_a_oe_n_in(aoe), .bus_b_in(b),
      .crossed_in(crossed), .far_drv_in(fdrv), .far_bit_in(fbit),
      .above_out(above), .below_out(below));

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction

   task automatic check(input string nm, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic stop_test();
      if (fails == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // 8 edges cover sync, filter and output flop
   task automatic pins(input logic [7:0] exp, msk);
      cyc(8);
      pin_q.push_back({msk, exp});
      smp <= 1'b1;
      @(posedge clk_in);
      smp <= 1'b0;
   endtask

   task automatic wr_reg(input logic [3:0] ad, input logic [31:0] d);
      addr <= ad;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] ad, input logic [31:0] exp);
      rd_q.push_back(exp);
      addr <= ad;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      cyc(2);
   endtask

   // all five status bits are compared
   always @(posedge clk_in) begin
      if (rd_seen) begin
         check("rdata", rdata & 32'h1F, rd_q.pop_front());
      end
      if (smp) begin
         pv = pin_q.pop_front();
         ov = {aoe, boe, a, b, soe, sb, swp, stby} & pv[15:8];
         check("pins", {24'h0, ov}, {24'h0, pv[7:0] & pv[15:8]});
         check("valid", {31'h0, sval}, 32'h1);
      end
      rd_seen <= rd;
   end

   initial begin
      repeat (20000) @(posedge clk_in);
      fails++;
      stop_test();
   end

   initial begin
      {talk, topen, lsn, lopen, txo, fdrv, fbit} = 7'h00;
      {txb, crossed, sys_rst_in} = 3'h7;
      {wr, rd, smp, rd_seen} = 4'h0;
      addr = 4'h0;
      wdata = 32'h0;
      rnd = 32'hCCBB;
      fails = 0;
      checks_done = 0;
      // second pass is a mid-run reset
      for (int run = 0; run < 2; run++) begin
         sys_rst_in <= 1'b1;
         cyc(6);
         sys_rst_in <= 1'b0;
         pins(8'hC0, M_RX);
         fdrv <= 1'b1;
         cyc(5);
         fdrv <= 1'b0;
         cyc(38);
         pins(8'hC0, M_RX);
         cyc(12);
         pins(8'hC6, M_RX);
      end
      lsn <= 1'b1;
      pins(8'hCA, 8'hCB);
      rd_reg(REG_STAT, 32'hB);
      cyc(30);
      pins(8'hCB, 8'hCB);
      lsn <= 1'b0;
      fdrv <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         rnd = xs(rnd);
         fbit <= rnd[0]; // short runs only
         pins({5'h18, rnd[0], 2'h2}, M_RX);
      end
      fdrv <= 1'b0;
      talk <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rnd = xs(rnd);
         txb <= rnd[1];
         // echo crosses the synchroniser twice
         cyc(3);
         pins({2'h0, ~rnd[1], rnd[1], 1'b0, rnd[1], 2'h2},
            8'hFF);
      end
      txb <= 1'b0;
      txo <= 1'b1;
      cyc(3);
      pins(8'h16, 8'hFF);
      txo <= 1'b0;
      topen <= 1'b1;
      pins(8'hC6, M_RX);
      // shared direction line driven low to receive
      {topen, talk, lsn, crossed} <= 4'h0;
      wr_reg(REG_CTRL, 32'h3);
      pins(8'hC4, M_RX);
      rd_reg(REG_CTRL, 32'h1);
      rd_reg(4'h8, 32'h0);
      cyc(60);
      pins(8'hC4, M_RX);
      talk <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         rnd = xs(rnd);
         txb <= rnd[2];
         cyc(3);
         pins({2'h0, rnd[2], ~rnd[2], 1'b0, rnd[2], 2'h0},
            8'hFF);
      end
      talk <= 1'b0;
      fdrv <= 1'b1;
      // own driver releases only after the sync delay
      cyc(3);
      for (int i = 0; i < 3; i++) begin
         rnd = xs(rnd);
         fbit <= rnd[3];
         pins({5'h18, rnd[3], 2'h0}, M_RX);
      end
      lopen <= 1'b1;
      pins(8'h08, 8'h08);
      for (int i = 0; i < 100 && pin_q.size() + rd_q.size() > 0; i++) begin
         cyc(1);
      end
      if (pin_q.size() + rd_q.size() > 0) begin
         fails++;
      end
      stop_test();
   end
endmodule
